/* core/hdrt_dma_timing.sv */
`timescale 1ns/1ps
`include "hdrt_params.svh"

module hdrt_dma_timing #(
  parameter int CNT_W = 9
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire hdrt_pkg::hdrt_dma_cfg_t cfg_i,
  input  wire logic                   ptr_low_write_i,
  input  wire logic                   fast_bus_timing_pin_i,
  input  wire logic                   fast_read_enable_bit_i,
  input  wire logic                   dma_ack_in_n_i,
  input  wire logic                   terminal_count_in_i,
  input  wire hdrt_pkg::hdrt_host_bus_t host_i,
  output logic                        dma_request_out_o,
  output logic                        dma_done_irq_o,
  output logic                        dma_active_o,
  output logic                        fast_read_active_o,
  output logic                        fast_write_active_o,
  output logic [2:0]                  rd_data_addr_o,
  output logic                        rd_data_sel_o,
  output hdrt_pkg::hdrt_rd_pulse_t    rd_pulse_o
);
  import hdrt_pkg::*;

  localparam int DLY_W = 5;

  typedef enum logic [5:0] {
    HDRT_IDLE  = 6'h01,
    HDRT_WAIT  = 6'h02,
    HDRT_REQ   = 6'h04,
    HDRT_ACKED = 6'h08,
    HDRT_HOLD  = 6'h10,
    HDRT_FIN   = 6'h20
  } hdrt_state_t;

  function automatic hdrt_rd_pulse_t decode_read(input logic [2:0] addr, input logic cs_n);
    hdrt_rd_pulse_t p;
    p.diagnostic_status_reg_clear     = !cs_n && (addr == `HDRT_ADDR_DIAGNOSTIC_STATUS_REG);
    p.ram_arb_start  = !cs_n && (addr == `HDRT_ADDR_DATA);
    p.next_node_read = !cs_n && (addr == `HDRT_ADDR_NEXT_NODE);
    return p;
  endfunction : decode_read

  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // raw pins: ack, tc, rd, wr, cs, addr[2:0], fast pin
  localparam int SYN_W = 9;
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic             rd_raw_n;
  logic             wr_raw_n;

  // direction/data-strobe hosts read while dir is high, write while low
  assign rd_raw_n = host_i.ds_mode ? (host_i.data_strobe_n || !host_i.dir_read)
                                   : host_i.host_read_strobe_n;
  assign wr_raw_n = host_i.ds_mode ? (host_i.data_strobe_n || host_i.dir_read)
                                   : host_i.host_write_strobe_n;
  assign pin_raw = {fast_bus_timing_pin_i, host_i.host_reg_addr, host_i.chip_select_n,
                    wr_raw_n, rd_raw_n, terminal_count_in_i, dma_ack_in_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          syn1_q[gi] <= 1'b1;
          syn2_q[gi] <= 1'b1;
        end else begin
          syn1_q[gi] <= pin_raw[gi];
          syn2_q[gi] <= syn1_q[gi];
        end
      end
    end
  endgenerate

  logic       ack_act;
  logic       tc_act;
  logic       rd_n;
  logic       wr_n;
  logic       cs_n;
  logic [2:0] addr;
  logic       strobe_act;

  assign ack_act    = !syn2_q[0];
  assign tc_act     = syn2_q[1] ^ cfg_i.count_input_polarity_sel;
  assign rd_n       = syn2_q[2];
  assign wr_n       = syn2_q[3];
  assign cs_n       = syn2_q[4];
  assign addr       = syn2_q[7:5];
  assign strobe_act = !rd_n || !wr_n;

  // ---------------------------------------------------------------
  // request state machine
  // ---------------------------------------------------------------
  hdrt_state_t state_q;
  hdrt_state_t state_d;
  logic [DLY_W-1:0] dly_q;
  logic [CNT_W-1:0] xfer_q;
  logic [CNT_W-1:0] tc_limit;
  logic [7:0]       burst_q;
  logic [DLY_W-1:0] tick_q;
  logic             xfer_prev_q;
  logic             xfer_now;
  logic             xfer_pulse;
  logic             single_m;
  logic             gated_m;
  logic             int_tc;
  logic             end_hit;
  logic             refresh_hit;
  logic [DLY_W-1:0] gate_cyc;

  assign single_m   = cfg_i.dma_transfer_mode_sel == `HDRT_MODE_SINGLE;
  assign gated_m    = cfg_i.dma_transfer_mode_sel[1];
  assign xfer_now   = ack_act && strobe_act;
  assign xfer_pulse = xfer_now && !xfer_prev_q;
  assign tc_limit   = {cfg_i.count_limit_msb, cfg_i.dma_count};
  assign int_tc     = !gated_m && xfer_pulse && (xfer_q + 9'h001 == tc_limit);
  // single mode needs the strobe alongside tc; demand takes tc under ack alone
  assign end_hit    = ack_act && (int_tc || (tc_act && (!single_m || strobe_act)));
  assign refresh_hit = gated_m && (burst_q >= cfg_i.dma_count) && (cfg_i.dma_count != 8'h00);
  assign gate_cyc   = cfg_i.gate_time_sel ? DLY_W'(`HDRT_GATE_LONG_CYC)
                                          : DLY_W'(`HDRT_GATE_SHORT_CYC);

  always_comb begin
    state_d = state_q;
    case (state_q)
      HDRT_IDLE: begin
        if (ptr_low_write_i && cfg_i.dma_request_enable) begin
          state_d = HDRT_WAIT;
        end
      end
      HDRT_WAIT: begin
        if (dly_q == DLY_W'(`HDRT_REQ_DELAY_CYC - 1)) begin
          state_d = HDRT_REQ;
        end
      end
      HDRT_REQ: begin
        if (end_hit) begin
          state_d = HDRT_FIN;
        end else if (single_m && xfer_now) begin
          state_d = HDRT_ACKED;
        end else if (refresh_hit) begin
          state_d = HDRT_HOLD;
        end
      end
      HDRT_ACKED: begin
        if (end_hit) begin
          state_d = HDRT_FIN;
        end else if (!xfer_now) begin
          state_d = HDRT_REQ;
        end
      end
      HDRT_HOLD: begin
        if (end_hit) begin
          state_d = HDRT_FIN;
        end else if (!ack_act && dly_q >= gate_cyc - DLY_W'(1)) begin
          state_d = HDRT_REQ;
        end
      end
      HDRT_FIN: begin
        if (!ack_act) begin
          state_d = HDRT_IDLE;
        end
      end
      default: state_d = HDRT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HDRT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // shared delay counter: request delay, then gate time after ack release
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= '0;
    end else if (state_q != state_d) begin
      dly_q <= '0;
    end else if ((state_q == HDRT_WAIT) || (state_q == HDRT_HOLD && !ack_act)) begin
      dly_q <= dly_q + DLY_W'(1);
    end else if (state_q == HDRT_HOLD) begin
      dly_q <= '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xfer_prev_q <= 1'b0;
      xfer_q      <= '0;
    end else begin
      xfer_prev_q <= xfer_now;
      if (state_q == HDRT_IDLE) begin
        xfer_q <= '0;
      end else if (xfer_pulse) begin
        xfer_q <= xfer_q + CNT_W'(1);
      end
    end
  end

  // burst length: timer ticks or transfer cycles, cleared at each burst start
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= 8'h00;
      tick_q  <= '0;
    end else if (state_q != HDRT_REQ) begin
      burst_q <= 8'h00;
      tick_q  <= '0;
    end else if (cfg_i.dma_transfer_mode_sel == `HDRT_MODE_GATE_TIM) begin
      if (tick_q == DLY_W'(`HDRT_TIM_TICK_CYC - 1)) begin
        tick_q  <= '0;
        burst_q <= burst_q + 8'h01;
      end else begin
        tick_q <= tick_q + DLY_W'(1);
      end
    end else if (xfer_pulse) begin
      burst_q <= burst_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // request pin and completion interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_request_out_o <= 1'b0;
      dma_done_irq_o    <= 1'b0;
      dma_active_o      <= 1'b0;
    end else begin
      dma_request_out_o <= (state_d == HDRT_REQ) ^ cfg_i.request_polarity_sel;
      dma_done_irq_o    <= (state_q == HDRT_FIN) && (state_d == HDRT_IDLE)
                           && cfg_i.dma_done_irq_mask;
      dma_active_o      <= state_d != HDRT_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // host read timing
  // ---------------------------------------------------------------
  logic [1:0]     rd_dly_q;
  logic [2:0]     addr_smp_q;
  logic           cs_smp_q;
  logic           rd_prev_q;
  logic           fast_rd;
  hdrt_rd_pulse_t pulse_d;

  assign fast_rd = !syn2_q[8] || fast_read_enable_bit_i;

  // falling edges are delayed one stage each, the rising edge clears both at once
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_dly_q <= 2'h0;
      rd_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= !rd_n;
      if (rd_n) begin
        rd_dly_q <= 2'h0;
      end else begin
        rd_dly_q <= {rd_dly_q[0], 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_smp_q <= 3'h0;
      cs_smp_q   <= 1'b1;
    end else if (!rd_n && !rd_dly_q[0]) begin
      addr_smp_q <= addr;
      cs_smp_q   <= cs_n;
    end
  end

  // fast path fires once the first delayed stage is set, before the second, with the captured address;
  // normal timing trusts the live address at the strobe edge
  always_comb begin
    pulse_d = '0;
    if (fast_rd) begin
      if (rd_dly_q[0] && !rd_dly_q[1] && !rd_n) begin
        pulse_d = decode_read(addr_smp_q, cs_smp_q);
      end
    end else if (!rd_n && !rd_prev_q) begin
      pulse_d = decode_read(addr, cs_n);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_pulse_o          <= '0;
      rd_data_addr_o      <= 3'h0;
      rd_data_sel_o       <= 1'b0;
      fast_read_active_o  <= 1'b0;
      fast_write_active_o <= 1'b0;
    end else begin
      rd_pulse_o          <= pulse_d;
      rd_data_addr_o      <= addr;
      rd_data_sel_o       <= !rd_n && !cs_n;
      fast_read_active_o  <= fast_rd;
      fast_write_active_o <= !syn2_q[8];
    end
  end

endmodule : hdrt_dma_timing

/* core/hdrt_params.svh */
`ifndef HDRT_PARAMS_SVH
`define HDRT_PARAMS_SVH

`define HDRT_CLK_PERIOD_NS   50
`define HDRT_ARB_PERIOD_NS   100
`define HDRT_ARB_PERIODS     4
`define HDRT_REQ_DELAY_CYC   ((`HDRT_ARB_PERIODS * `HDRT_ARB_PERIOD_NS + `HDRT_CLK_PERIOD_NS - 1) \
                              / `HDRT_CLK_PERIOD_NS)
`define HDRT_GATE_SHORT_NS   350
`define HDRT_GATE_LONG_NS    750
`define HDRT_GATE_SHORT_CYC  ((`HDRT_GATE_SHORT_NS + `HDRT_CLK_PERIOD_NS - 1) / `HDRT_CLK_PERIOD_NS)
`define HDRT_GATE_LONG_CYC   ((`HDRT_GATE_LONG_NS + `HDRT_CLK_PERIOD_NS - 1) / `HDRT_CLK_PERIOD_NS)
`define HDRT_TIM_TICK_NS     1000
`define HDRT_TIM_TICK_CYC    (`HDRT_TIM_TICK_NS / `HDRT_CLK_PERIOD_NS)
`define HDRT_RD_DLY1_NS      15
`define HDRT_RD_DLY2_NS      10
`define HDRT_RD_DLY1_CYC     ((`HDRT_RD_DLY1_NS + `HDRT_CLK_PERIOD_NS - 1) / `HDRT_CLK_PERIOD_NS)
`define HDRT_RD_DLY2_CYC     ((`HDRT_RD_DLY2_NS + `HDRT_CLK_PERIOD_NS - 1) / `HDRT_CLK_PERIOD_NS)
`define HDRT_MODE_SINGLE     2'h0
`define HDRT_MODE_DEMAND     2'h1
`define HDRT_MODE_GATE_TIM   2'h2
`define HDRT_MODE_GATE_CYC   2'h3
`define HDRT_MODE_POS        3
`define HDRT_ADDR_DATA       3'h4
`define HDRT_ADDR_DIAGNOSTIC_STATUS_REG       3'h1
`define HDRT_ADDR_NEXT_NODE  3'h7

`endif

/* core/hdrt_pkg.sv */
package hdrt_pkg;

  typedef struct packed {
    logic       dma_request_enable;
    logic [1:0] dma_transfer_mode_sel;
    logic       request_polarity_sel;
    logic       count_input_polarity_sel;
    logic       count_limit_msb;
    logic [7:0] dma_count;
    logic       gate_time_sel;
    logic       dma_done_irq_mask;
  } hdrt_dma_cfg_t;

  typedef struct packed {
    logic [2:0] host_reg_addr;
    logic       chip_select_n;
    logic       host_read_strobe_n;
    logic       host_write_strobe_n;
    logic       data_strobe_n;
    logic       dir_read;
    logic       ds_mode;
  } hdrt_host_bus_t;

  typedef struct packed {
    logic       diagnostic_status_reg_clear;
    logic       ram_arb_start;
    logic       next_node_read;
  } hdrt_rd_pulse_t;

endpackage : hdrt_pkg

/* dv/hdrt_dma_timing_checker.sv */
`timescale 1ns/1ps
`include "hdrt_params.svh"
module hdrt_dma_timing_checker #(
  parameter int CNT_W = 9
) (
  input wire logic                     ref_clk_i,
  input wire logic                     rst_n_i,
  input wire hdrt_pkg::hdrt_dma_cfg_t  cfg_i,
  input wire logic                     ptr_low_write_i,
  input wire logic                     fast_bus_timing_pin_i,
  input wire logic                     fast_read_enable_bit_i,
  input wire logic                     dma_ack_in_n_i,
  input wire logic                     terminal_count_in_i,
  input wire hdrt_pkg::hdrt_host_bus_t host_i,
  input wire logic                     dma_request_out_o,
  input wire logic                     dma_done_irq_o,
  input wire logic                     dma_active_o,
  input wire logic                     fast_read_active_o,
  input wire logic                     fast_write_active_o,
  input wire logic [2:0]               rd_data_addr_o,
  input wire logic                     rd_data_sel_o,
  input wire hdrt_pkg::hdrt_rd_pulse_t rd_pulse_o
);
  import hdrt_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       req_act;
  logic       tc_act;
  logic [3:0] up_q;
  assign req_act = dma_request_out_o ^ cfg_i.request_polarity_sel;
  assign tc_act  = terminal_count_in_i ^ cfg_i.count_input_polarity_sel;
  // pin synchronisers need a few edges after reset before levels mean anything
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hf) begin
      up_q <= up_q + 4'h1;
    end
  end
  sequence s_ack_strobe;
    (cfg_i.dma_transfer_mode_sel == `HDRT_MODE_SINGLE && !dma_ack_in_n_i
     && !host_i.host_write_strobe_n)[*5];
  endsequence
  sequence s_no_tc;
    (cfg_i.dma_transfer_mode_sel == `HDRT_MODE_DEMAND && req_act && !tc_act
     && {cfg_i.count_limit_msb, cfg_i.dma_count} == 9'h000)[*4];
  endsequence
  sequence s_steady;
    (up_q == 4'hf && $stable(fast_bus_timing_pin_i) && $stable(fast_read_enable_bit_i))[*6];
  endsequence
  property p_req_delay;
    ptr_low_write_i && cfg_i.dma_request_enable && !dma_active_o
      |=> (!req_act)[*7] ##[1:6] req_act;
  endproperty
  property p_no_start;
    ptr_low_write_i && !cfg_i.dma_request_enable && !dma_active_o
      |=> (!dma_active_o && !req_act)[*6];
  endproperty
  property p_single_drop;
    s_ack_strobe |-> !req_act;
  endproperty
  property p_demand_hold;
    s_no_tc |=> req_act;
  endproperty
  property p_irq;
    dma_done_irq_o |-> cfg_i.dma_done_irq_mask ##1 !dma_done_irq_o;
  endproperty
  property p_gate;
    cfg_i.dma_transfer_mode_sel[1] && $rose(dma_ack_in_n_i) |=> (!req_act)[*7];
  endproperty
  property p_fast_map;
    s_steady |-> fast_read_active_o == (!fast_bus_timing_pin_i || fast_read_enable_bit_i)
      && fast_write_active_o == !fast_bus_timing_pin_i;
  endproperty
  property p_pulse;
    rd_pulse_o != 3'h0 |-> $onehot(rd_pulse_o) ##1 rd_pulse_o == 3'h0;
  endproperty
  property p_diagnostic_status_reg;
    rd_pulse_o.diagnostic_status_reg_clear |-> $past(host_i.host_reg_addr, 2) == `HDRT_ADDR_DIAGNOSTIC_STATUS_REG
      && !$past(host_i.chip_select_n, 2);
  endproperty
  a_req_delay: assert property (p_req_delay) else $error("request delay wrong");
  a_no_start: assert property (p_no_start) else $error("started while disabled");
  a_single_drop: assert property (p_single_drop) else $error("single request held");
  a_demand_hold: assert property (p_demand_hold) else $error("demand request fell");
  a_irq: assert property (p_irq) else $error("done pulse wrong");
  a_gate: assert property (p_gate) else $error("gate time too short");
  a_fast_map: assert property (p_fast_map) else $error("fast timing wrong");
  a_pulse: assert property (p_pulse) else $error("read pulse shape wrong");
  a_diagnostic_status_reg: assert property (p_diagnostic_status_reg) else $error("clear pulse wrong address");
endmodule : hdrt_dma_timing_checker

bind hdrt_dma_timing hdrt_dma_timing_checker #(
  .CNT_W(CNT_W)
) u_hdrt_dma_timing_checker (
  .ref_clk_i              (ref_clk_i),
  .rst_n_i                (rst_n_i),
  .cfg_i                  (cfg_i),
  .ptr_low_write_i        (ptr_low_write_i),
  .fast_bus_timing_pin_i  (fast_bus_timing_pin_i),
  .fast_read_enable_bit_i (fast_read_enable_bit_i),
  .dma_ack_in_n_i         (dma_ack_in_n_i),
  .terminal_count_in_i    (terminal_count_in_i),
  .host_i                 (host_i),
  .dma_request_out_o      (dma_request_out_o),
  .dma_done_irq_o         (dma_done_irq_o),
  .dma_active_o           (dma_active_o),
  .fast_read_active_o     (fast_read_active_o),
  .fast_write_active_o    (fast_write_active_o),
  .rd_data_addr_o         (rd_data_addr_o),
  .rd_data_sel_o          (rd_data_sel_o),
  .rd_pulse_o             (rd_pulse_o)
);

/* dv/hdrt_dma_ctl_model.sv */
`timescale 1ns/1ps
module hdrt_dma_ctl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic       pol_i,
  input  wire logic       tc_pol_i,
  input  wire logic [9:0] last_i,
  input  wire logic       slow_i,
  output logic            ack_n_o,
  output logic            wr_n_o,
  output logic            tc_o,
  output logic [9:0]      cnt_o
);
  logic act;
  logic tc_on;
  assign act  = req_i ^ pol_i;
  assign tc_o = tc_on ^ tc_pol_i;
  initial begin
    ack_n_o = 1'b1;
    wr_n_o  = 1'b1;
    tc_on   = 1'b0;
    cnt_o   = 10'h0;
    forever begin
      @(posedge ref_clk_i);
      // look after the edge settles: a polarity flip lands a cycle before the pin follows
      #1;
      if (rst_n_i === 1'b1 && act === 1'b1) begin
        repeat (slow_i ? 3 : 1) @(posedge ref_clk_i);
        #2 ack_n_o = 1'b0;
        do begin
          wr_n_o = 1'b0;
          tc_on  = (cnt_o + 10'h1 == last_i);
          repeat (6) @(posedge ref_clk_i);
          #2 wr_n_o = 1'b1;
          tc_on = 1'b0;
          cnt_o = cnt_o + 10'h1;
          repeat (2) @(posedge ref_clk_i);
          #2;
        end while (act === 1'b1);
        // let go only once the request is down and the cycle has ended
        ack_n_o = 1'b1;
      end
    end
  end
endmodule : hdrt_dma_ctl_model

/* dv/hdrt_dma_timing_test.sv */
`timescale 1ns/1ps
`include "hdrt_params.svh"
module hdrt_dma_timing_test;
  import hdrt_pkg::*;
  hdrt_dma_cfg_t  cfg;
  hdrt_host_bus_t host;
  hdrt_host_bus_t host_w;
  hdrt_rd_pulse_t pulse;
  logic           ref_clk_i, rst_n_i, ptr_wr, pin, rbit, slow, pol;
  logic           ack_n, tc, wr_n, req, irq, act, frd, fwr, rds;
  logic [2:0]     rda;
  logic [9:0]     last, p_cnt;
  logic [3:0]     q[$];
  int             seed, mismatches, tests_run;
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always_comb begin
    host_w = host;
    host_w.host_write_strobe_n = wr_n;
  end
  hdrt_dma_timing u_hdrt_dma_timing (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
    .ptr_low_write_i(ptr_wr), .fast_bus_timing_pin_i(pin), .fast_read_enable_bit_i(rbit),
    .dma_ack_in_n_i(ack_n), .terminal_count_in_i(tc), .host_i(host_w),
    .dma_request_out_o(req), .dma_done_irq_o(irq), .dma_active_o(act),
    .fast_read_active_o(frd), .fast_write_active_o(fwr), .rd_data_addr_o(rda),
    .rd_data_sel_o(rds), .rd_pulse_o(pulse));
  hdrt_dma_ctl_model u_hdrt_dma_ctl_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .req_i(req), .pol_i(cfg.request_polarity_sel), .tc_pol_i(cfg.count_input_polarity_sel),
    .last_i(last), .slow_i(slow), .ack_n_o(ack_n), .wr_n_o(wr_n), .tc_o(tc), .cnt_o(p_cnt));
  task automatic step;
    @(posedge ref_clk_i);
    #2;
  endtask : step
  task automatic cmp_evt(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_evt
  task automatic cmp_lvl(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_lvl
  task automatic print_verdict;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // -------------------------------------------------------------------------
  // pulse and done watcher: every event must match the oldest note
  // -------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_n_i === 1'b1 && (irq !== 1'b0 || pulse !== 3'h0)) begin
      cmp_evt({irq, pulse}, q.size() > 0 ? q.pop_front() : 4'h0);
    end
  end
  // address moves as the strobe rises, the hazard the delayed capture guards against
  task automatic rd_once(input logic ds);
    logic [2:0] a;
    logic       c;
    logic [2:0] e;
    a = 3'($random(seed));
    c = (2'($random(seed)) == 2'h0);
    e = c ? 3'h0 : (a == `HDRT_ADDR_DIAGNOSTIC_STATUS_REG) ? 3'h4 : (a == `HDRT_ADDR_DATA) ? 3'h2 :
        (a == `HDRT_ADDR_NEXT_NODE) ? 3'h1 : 3'h0;
    if (e != 3'h0) q.push_back({1'b0, e});
    host = '{a, c, ds, 1'b1, ~ds, ds, ds};
    repeat (6) step;
    cmp_lvl({6'h0, rda, rds}, {6'h0, a, ~c});
    host = '{~a, c, 1'b1, 1'b1, 1'b1, ds, ds};
    repeat (8) step;
    cmp_lvl({6'h0, rda, rds}, {6'h0, ~a, 1'b0});
  endtask : rd_once
  task automatic run_dma(input logic [1:0] md, input logic en, input logic [8:0] cn,
                         input logic [9:0] tcn, input logic [9:0] nx, input logic mk);
    logic [9:0] b;
    pol = ~pol;
    slow = 1'($random(seed));
    b = p_cnt;
    last = b + tcn;
    cfg = '{en, md, pol, pol, cn[8], cn[7:0], 1'($random(seed)), mk};
    repeat (4) step;
    ptr_wr = 1'b1;
    step;
    ptr_wr = 1'b0;
    if (en && mk) q.push_back(4'h8);
    repeat (12) step;
    for (int k = 0; k < 20000 && act !== 1'b0; k++) step;
    repeat (40) step;
    cmp_lvl(p_cnt - b, nx);
    cmp_lvl({9'h0, req ^ pol}, 10'h0);
    cmp_lvl({9'h0, act}, 10'h0);
  endtask : run_dma
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    seed = 16;
    mismatches = 0;
    tests_run = 0;
    {rst_n_i, ptr_wr, rbit, slow, pol, last} = '0;
    pin = 1'b1;
    cfg = '0;
    host = '{3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    repeat (16) @(posedge ref_clk_i);
    #2 rst_n_i = 1'b1;
    repeat (8) step;
    for (int i = 0; i < 4; i++) begin
      {pin, rbit} = 2'(i);
      repeat (8) step;
      cmp_lvl({8'h0, frd, fwr}, {8'h0, ~pin | rbit, ~pin});
    end
    for (int i = 0; i < 32; i++) begin
      {rbit, pin} = {i[2], i[0]};
      repeat (4) step;
      rd_once(i[1]);
    end
    host = '{3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    run_dma(`HDRT_MODE_SINGLE, 1'b1, 9'h003, 10'd3, 10'd3, 1'b1);
    run_dma(`HDRT_MODE_SINGLE, 1'b1, 9'h000, 10'd4, 10'd4, 1'b1);
    run_dma(`HDRT_MODE_DEMAND, 1'b1, 9'h000, 10'd6, 10'd6, 1'b1);
    run_dma(`HDRT_MODE_DEMAND, 1'b1, 9'h102, 10'd400, 10'd258, 1'b0);
    run_dma(`HDRT_MODE_GATE_TIM, 1'b1, 9'h002, 10'd9, 10'd9, 1'b1);
    run_dma(`HDRT_MODE_GATE_CYC, 1'b1, 9'h003, 10'd7, 10'd7, 1'b0);
    run_dma(`HDRT_MODE_DEMAND, 1'b0, 9'h000, 10'd3, 10'd0, 1'b1);
    cmp_lvl(10'(q.size()), 10'h0);
    print_verdict();
  end
  // whole run needs well under ten thousand cycles; forty thousand means a hang
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule : hdrt_dma_timing_test
